/* File: design/servo_pkg.sv */
package servo_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses of aligned 32-bit words
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INPOS_WINDOW = 8'h00;
    localparam logic [7:0] ADDR_FUNC_ONE = 8'h04;
    localparam logic [7:0] ADDR_FUNC_TWO = 8'h08;
    localparam logic [7:0] ADDR_NOTCH_ONE_FREQ = 8'h0c;
    localparam logic [7:0] ADDR_NOTCH_TWO_FREQ = 8'h10;
    localparam logic [7:0] ADDR_FUNC_SIX = 8'h14;
    localparam logic [7:0] ADDR_NOTCH_FOUR_FREQ = 8'h18;
    localparam logic [7:0] ADDR_NOTCH_FIVE_FREQ = 8'h1c;
    localparam logic [7:0] ADDR_PRIMARY_GAIN = 8'h20;
    localparam logic [7:0] ADDR_HIGH_SPEED_GAIN = 8'h24;
    localparam logic [7:0] ADDR_GAIN_CHANGE_SPEED = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_RESONANCE_MON = 8'h30;
    localparam logic [7:0] ADDR_SETTLE_TIME = 8'h34;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] INPOS_WINDOW_RESET = 16'h0032;
    localparam logic [15:0] INPOS_WINDOW_MAX = 16'h7fff;
    localparam logic [15:0] PRIMARY_GAIN_RESET = 16'h0064;
    localparam logic [15:0] GAIN_MIN = 16'h0001;
    localparam logic [15:0] GAIN_MAX = 16'h270f;
    localparam logic [15:0] SPEED_MAX = 16'h270f;
    localparam logic [15:0] NOTCH_FREQ_MAX = 16'h08ca;
    localparam logic [15:0] FIXED_NOTCH_FREQ = 16'h0465;

    // ------------------------------------------------------------
    // Field positions in the function words
    // ------------------------------------------------------------
    localparam int JITTER_LSB = 4;
    localparam int HIGH_DEPTH_LSB = 5;
    localparam int LOW_DEPTH_LSB = 1;
    localparam int FIXED_NOTCH_EN_BIT = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CONTROL_CYCLE_US = 1000;
    localparam int CONTROL_CYCLE_CLKS = (CONTROL_CYCLE_US * 1000) / CLK_PERIOD_PS;

    // Attenuation in tenths of a dB per depth code, 8'hff meaning infinite.
    localparam logic [7:0] DEPTH_ATTEN [8] = '{8'hff, 8'hb5, 8'h78, 8'h55, 8'h3c, 8'h29, 8'h19, 8'h0c};

    typedef struct packed {
        logic enable;
        logic [2:0] depth;
        logic [7:0] atten_tenth_db;
        logic [15:0] freq_hz;
    } notch_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

/* File: design/servo_vib_inpos.sv */
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// R1: Controller waits for in-position before next block.
// R2: Window accepts 0 to 32767, reset 50.
// R3: Settling counted from feed zero to in-position.
// R4: In-position when droop magnitude within window.
// R5: Five independent notch filters, separately configured.
// R6: Filter three fixed 1125 Hz, enable bit.
// R7: Three-bit depth codes map to attenuations.
// R8: Word two holds depths two, one, enable.
// R9: Word six holds depths five and four.
// R10: Notch frequency 0 to 2250, zero disables.
// R11: Software avoids notch frequencies 80 or below.
// R12: Resonance monitor reports zero without resonance.
// R13: Ignore set pulses after feedback polarity reversal.
// R14: Word one bits 5-4 pick pulse count.
// R15: Masking only while motor stopped.
// R16: Primary gain 1 to 9999, normal gain.
// R17: Lower gain at high speed, primary when slow.
// R18: Above change speed use secondary; zero disables.
module servo_vib_inpos
    import servo_pkg::*;
#(
    parameter int CYCLE_CLKS = servo_pkg::CONTROL_CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire servo_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [31:0] position_droop,
    input wire logic [15:0] feed_increment,
    input wire logic speed_fb_pulse,
    input wire logic speed_fb_dir,
    input wire logic [15:0] motor_speed,
    input wire logic resonance_present,
    input wire logic [15:0] resonance_freq,
    output logic in_position,
    output logic speed_fb_pulse_out,
    output logic speed_fb_dir_out,
    output logic [15:0] speed_gain,
    output servo_pkg::notch_cfg_t [4:0] notch_cfg
);
    import servo_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [15:0] window_q;
    logic [15:0] func_one_q;
    logic [15:0] func_two_q;
    logic [15:0] func_six_q;
    logic [15:0] freq_q [4];
    logic [15:0] primary_gain_q;
    logic [15:0] high_gain_q;
    logic [15:0] change_speed_q;
    logic [15:0] resonance_mon_q;
    logic [15:0] settle_time_q;
    logic settle_valid_q;
    logic [31:0] rdata_d;
    logic mapped_d;
    logic wr_en;
    logic [15:0] wval;

    assign wr_en = apb_req.psel && apb_req.penable && pready;
    assign wval = apb_req.pwdata[15:0];

    always_comb begin
        rdata_d = 32'h0000_0000;
        mapped_d = 1'b1;
        case (apb_req.paddr)
            ADDR_INPOS_WINDOW: rdata_d[15:0] = window_q;
            ADDR_FUNC_ONE: rdata_d[15:0] = func_one_q;
            ADDR_FUNC_TWO: rdata_d[15:0] = func_two_q;
            ADDR_NOTCH_ONE_FREQ: rdata_d[15:0] = freq_q[0];
            ADDR_NOTCH_TWO_FREQ: rdata_d[15:0] = freq_q[1];
            ADDR_FUNC_SIX: rdata_d[15:0] = func_six_q;
            ADDR_NOTCH_FOUR_FREQ: rdata_d[15:0] = freq_q[2];
            ADDR_NOTCH_FIVE_FREQ: rdata_d[15:0] = freq_q[3];
            ADDR_PRIMARY_GAIN: rdata_d[15:0] = primary_gain_q;
            ADDR_HIGH_SPEED_GAIN: rdata_d[15:0] = high_gain_q;
            ADDR_GAIN_CHANGE_SPEED: rdata_d[15:0] = change_speed_q;
            ADDR_STATUS: rdata_d[1:0] = {settle_valid_q, in_position};
            ADDR_RESONANCE_MON: rdata_d[15:0] = resonance_mon_q;
            ADDR_SETTLE_TIME: rdata_d[15:0] = settle_time_q;
            default: mapped_d = 1'b0;
        endcase
    end

    // A wait state keeps every answer on a flip-flop; each access takes two cycles of penable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_req.psel && apb_req.penable && !pready;
            prdata <= (apb_req.pwrite) ? 32'h0000_0000 : rdata_d;
            pslverr <= !mapped_d && apb_req.psel && apb_req.penable && !pready;
        end
    end

    // Out-of-range writes are clamped so the loop never sees an illegal setting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_q <= INPOS_WINDOW_RESET;
            func_one_q <= 16'h0000;
            func_two_q <= 16'h0000;
            func_six_q <= 16'h0000;
            freq_q <= '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
            primary_gain_q <= PRIMARY_GAIN_RESET;
            high_gain_q <= 16'h0000;
            change_speed_q <= 16'h0000;
        end else if (wr_en && apb_req.pwrite) begin
            case (apb_req.paddr)
                ADDR_INPOS_WINDOW: window_q <= (wval > INPOS_WINDOW_MAX) ? INPOS_WINDOW_MAX : wval; // R2
                ADDR_FUNC_ONE: func_one_q <= wval;
                ADDR_FUNC_TWO: func_two_q <= wval;
                ADDR_FUNC_SIX: func_six_q <= wval;
                ADDR_NOTCH_ONE_FREQ: freq_q[0] <= (wval > NOTCH_FREQ_MAX) ? NOTCH_FREQ_MAX : wval; // R10
                ADDR_NOTCH_TWO_FREQ: freq_q[1] <= (wval > NOTCH_FREQ_MAX) ? NOTCH_FREQ_MAX : wval; // R10
                ADDR_NOTCH_FOUR_FREQ: freq_q[2] <= (wval > NOTCH_FREQ_MAX) ? NOTCH_FREQ_MAX : wval; // R10
                ADDR_NOTCH_FIVE_FREQ: freq_q[3] <= (wval > NOTCH_FREQ_MAX) ? NOTCH_FREQ_MAX : wval; // R10
                ADDR_PRIMARY_GAIN: begin
                    primary_gain_q <= (wval < GAIN_MIN) ? GAIN_MIN : ((wval > GAIN_MAX) ? GAIN_MAX : wval); // R16
                end
                ADDR_HIGH_SPEED_GAIN: high_gain_q <= (wval > GAIN_MAX) ? GAIN_MAX : wval;
                ADDR_GAIN_CHANGE_SPEED: change_speed_q <= (wval > SPEED_MAX) ? SPEED_MAX : wval;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control cycle divider
    // ------------------------------------------------------------
    logic [31:0] div_q;
    logic tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 32'(CYCLE_CLKS - 1));
            div_q <= (div_q == 32'(CYCLE_CLKS - 1)) ? 32'h0000_0000 : div_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // In-position and settling time
    // ------------------------------------------------------------
    logic [31:0] droop_mag;
    logic inpos_d;
    logic [15:0] feed_prev_q;
    logic settling_q;
    logic [15:0] settle_cnt_q;

    assign droop_mag = position_droop[31] ? 32'(-position_droop) : 32'(position_droop);
    assign inpos_d = (droop_mag <= {16'h0000, window_q});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_position <= 1'b0;
        end else if (tick_q) begin
            in_position <= inpos_d; // R4 R1
        end
    end

    // The count saturates rather than wrapping, but the time stored is count plus one, so a settle after saturation reads as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feed_prev_q <= 16'h0000;
            settling_q <= 1'b0;
            settle_cnt_q <= 16'h0000;
            settle_time_q <= 16'h0000;
            settle_valid_q <= 1'b0;
        end else if (tick_q) begin
            feed_prev_q <= feed_increment;
            if (feed_increment != 16'h0000) begin
                settling_q <= 1'b0;
            end else if (feed_prev_q != 16'h0000) begin
                settling_q <= !inpos_d; // R3
                settle_cnt_q <= 16'h0000;
                settle_valid_q <= inpos_d;
                settle_time_q <= 16'h0000;
            end else if (settling_q) begin
                if (inpos_d) begin
                    settling_q <= 1'b0; // R3
                    settle_time_q <= settle_cnt_q + 16'h0001;
                    settle_valid_q <= 1'b1;
                end else if (settle_cnt_q != 16'hffff) begin
                    settle_cnt_q <= settle_cnt_q + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Notch filter bank
    // ------------------------------------------------------------
    logic [2:0] depth_code [5];

    assign depth_code[0] = func_two_q[LOW_DEPTH_LSB +: 3]; // R8
    assign depth_code[1] = func_two_q[HIGH_DEPTH_LSB +: 3]; // R8
    assign depth_code[2] = 3'h0;
    assign depth_code[3] = func_six_q[LOW_DEPTH_LSB +: 3]; // R9
    assign depth_code[4] = func_six_q[HIGH_DEPTH_LSB +: 3]; // R9

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_notch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    // Reset mirrors the reset registers, so no output ever shows a setting that none holds.
                    notch_cfg[gi] <= '{1'b0, 3'h0, DEPTH_ATTEN[0], (gi == 2) ? FIXED_NOTCH_FREQ : 16'h0000};
                end else if (gi == 2) begin
                    notch_cfg[gi].enable <= func_two_q[FIXED_NOTCH_EN_BIT]; // R6
                    notch_cfg[gi].depth <= 3'h0;
                    notch_cfg[gi].atten_tenth_db <= DEPTH_ATTEN[0];
                    notch_cfg[gi].freq_hz <= FIXED_NOTCH_FREQ; // R6
                end else begin
                    notch_cfg[gi].enable <= (freq_q[(gi > 2) ? gi - 1 : gi] != 16'h0000); // R10 R5
                    notch_cfg[gi].depth <= depth_code[gi];
                    notch_cfg[gi].atten_tenth_db <= DEPTH_ATTEN[depth_code[gi]]; // R7
                    notch_cfg[gi].freq_hz <= freq_q[(gi > 2) ? gi - 1 : gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resonance_mon_q <= 16'h0000;
        end else begin
            resonance_mon_q <= resonance_present ? resonance_freq : 16'h0000; // R12
        end
    end

    // ------------------------------------------------------------
    // Jitter compensation
    // ------------------------------------------------------------
    logic last_dir_q;
    logic [1:0] mask_q;
    logic stopped;
    logic reversal;
    logic [1:0] jitter_sel;

    assign stopped = (motor_speed == 16'h0000);
    assign jitter_sel = func_one_q[JITTER_LSB +: 2]; // R14
    assign reversal = speed_fb_pulse && (speed_fb_dir != last_dir_q);

    // Only the speed path is masked; position feedback is taken elsewhere, untouched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_dir_q <= 1'b0;
            mask_q <= 2'h0;
            speed_fb_pulse_out <= 1'b0;
            speed_fb_dir_out <= 1'b0;
        end else begin
            speed_fb_dir_out <= speed_fb_dir;
            speed_fb_pulse_out <= speed_fb_pulse;
            if (speed_fb_pulse) begin
                last_dir_q <= speed_fb_dir;
                if (!stopped || jitter_sel == 2'h0) begin
                    mask_q <= 2'h0; // R15
                end else if (reversal) begin
                    mask_q <= jitter_sel - 2'h1; // R13
                    speed_fb_pulse_out <= 1'b0; // R13
                end else if (mask_q != 2'h0) begin
                    mask_q <= mask_q - 2'h1;
                    speed_fb_pulse_out <= 1'b0; // R13
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Variable speed loop gain
    // ------------------------------------------------------------
    logic high_speed;

    assign high_speed = (change_speed_q != 16'h0000) && (high_gain_q != 16'h0000) && (motor_speed > change_speed_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_gain <= PRIMARY_GAIN_RESET;
        end else begin
            speed_gain <= high_speed ? high_gain_q : primary_gain_q; // R16 R17 R18
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_inpos;
        @(posedge pclk) disable iff (!presetn) tick_q |=> (in_position == $past(inpos_d));
    endproperty
    a_inpos: assert property (p_inpos) else $error("in-position does not follow droop"); // R4

    property p_window_max;
        @(posedge pclk) disable iff (!presetn) window_q <= INPOS_WINDOW_MAX;
    endproperty
    a_window_max: assert property (p_window_max) else $error("window above limit"); // R2

    property p_settle_start;
        @(posedge pclk) disable iff (!presetn)
            tick_q && feed_increment == 16'h0000 && feed_prev_q != 16'h0000 && !inpos_d |=> settling_q;
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("settling not started"); // R3

    property p_fixed_notch;
        @(posedge pclk) disable iff (!presetn)
            ##1 notch_cfg[2].freq_hz == FIXED_NOTCH_FREQ && notch_cfg[2].enable == $past(func_two_q[FIXED_NOTCH_EN_BIT]);
    endproperty
    a_fixed_notch: assert property (p_fixed_notch) else $error("fixed notch wrong"); // R6

    property p_depth_two;
        @(posedge pclk) disable iff (!presetn) ##1 notch_cfg[1].depth == $past(func_two_q[7:5]);
    endproperty
    a_depth_two: assert property (p_depth_two) else $error("notch two depth wrong"); // R8

    property p_depth_five;
        @(posedge pclk) disable iff (!presetn)
            ##1 notch_cfg[4].atten_tenth_db == DEPTH_ATTEN[$past(func_six_q[7:5])];
    endproperty
    a_depth_five: assert property (p_depth_five) else $error("notch five attenuation wrong"); // R9

    property p_zero_freq;
        @(posedge pclk) disable iff (!presetn) ##1 (notch_cfg[0].enable == ($past(freq_q[0]) != 16'h0000));
    endproperty
    a_zero_freq: assert property (p_zero_freq) else $error("notch one enable wrong"); // R10

    property p_res_mon;
        @(posedge pclk) disable iff (!presetn) !resonance_present |=> resonance_mon_q == 16'h0000;
    endproperty
    a_res_mon: assert property (p_res_mon) else $error("monitor not zero"); // R12

    property p_moving_pass;
        @(posedge pclk) disable iff (!presetn) speed_fb_pulse && !stopped |=> speed_fb_pulse_out;
    endproperty
    a_moving_pass: assert property (p_moving_pass) else $error("pulse masked while moving"); // R15

    property p_reversal_mask;
        @(posedge pclk) disable iff (!presetn)
            reversal && stopped && jitter_sel != 2'h0 |=> !speed_fb_pulse_out;
    endproperty
    a_reversal_mask: assert property (p_reversal_mask) else $error("reversal pulse passed"); // R13

    property p_gain;
        @(posedge pclk) disable iff (!presetn)
            change_speed_q == 16'h0000 ##1 change_speed_q == 16'h0000 |-> speed_gain == $past(primary_gain_q);
    endproperty
    a_gain: assert property (p_gain) else $error("gain reduced while disabled"); // R18

endmodule

/* File: test/cnc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Controller model: bursts of two moves
// ----------------------------------------
module cnc_model #(
    parameter int CYCLE = 8
) (
    input wire logic pclk,
    input wire logic run,
    input wire logic signed [31:0] droop_in,
    input wire logic in_position,
    output logic [15:0] feed_increment,
    output logic signed [31:0] position_droop,
    output int blocks_done
);
    int n;
    initial begin
        feed_increment = 16'h0000;
        position_droop = 32'sd0;
        blocks_done = 0;
        forever begin
            @(posedge pclk);
            if (run === 1'b1) begin
                repeat (2) begin
                    feed_increment <= 16'h0010;
                    position_droop <= 32'sd400;
                    repeat (4 * CYCLE) @(posedge pclk);
                    feed_increment <= 16'h0000;
                    repeat (3 * CYCLE) @(posedge pclk);
                    position_droop <= 32'sd10;
                    n = 0;
                    // The wait is bounded so that a stuck flag delays each move by at most 100 cycles instead of stalling it.
                    while (in_position !== 1'b1 && n < 100) begin
                        @(posedge pclk);
                        n++;
                    end
                    blocks_done <= blocks_done + 1;
                end
            end else begin
                position_droop <= droop_in;
            end
        end
    end
endmodule

/* File: test/servo_vib_inpos_tb.sv */
`timescale 1ns/1ps
module servo_vib_inpos_tb;
    import servo_pkg::*;
    // ----------------------------------------
    // Signals and scoreboard
    // ----------------------------------------
    localparam int CYCLE = 8;
    typedef struct packed {
        logic cmp;
        logic err;
        logic [31:0] data;
    } note_t;
    note_t expq[$];
    note_t e;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, in_position, pulse_out, dir_out;
    logic pulse_in = 1'b0;
    logic dir_in = 1'b0;
    logic res_present = 1'b0;
    logic run = 1'b0;
    logic signed [31:0] droop_in = 32'sd0;
    logic signed [31:0] position_droop;
    logic [15:0] feed_increment, speed_gain;
    logic [15:0] motor_speed = 16'h0000;
    logic [15:0] resonance_freq = 16'h0000;
    notch_cfg_t [4:0] notch_cfg;
    int blocks_done, n0;
    int failures = 0;
    int checks = 0;
    int pulse_cnt = 0;
    int seed = 32'he15ac1d7;
    // Tenths of a dB for each depth code; ff stands for infinite.
    logic [7:0] atten [8] = '{8'hff, 8'hb5, 8'h78, 8'h55, 8'h3c, 8'h29, 8'h19, 8'h0c};
    logic [7:0] fa [5] = '{ADDR_NOTCH_ONE_FREQ, ADDR_NOTCH_TWO_FREQ, 8'h00, ADDR_NOTCH_FOUR_FREQ, ADDR_NOTCH_FIVE_FREQ};

    initial forever #2.5 pclk = ~pclk;

    servo_vib_inpos #(.CYCLE_CLKS(CYCLE)) servo_vib_inpos_inst (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .position_droop(position_droop), .feed_increment(feed_increment), .speed_fb_pulse(pulse_in),
        .speed_fb_dir(dir_in), .motor_speed(motor_speed), .resonance_present(res_present),
        .resonance_freq(resonance_freq), .in_position(in_position), .speed_fb_pulse_out(pulse_out),
        .speed_fb_dir_out(dir_out), .speed_gain(speed_gain), .notch_cfg(notch_cfg));
    cnc_model #(.CYCLE(CYCLE)) cnc_model_inst (.pclk(pclk), .run(run), .droop_in(droop_in),
        .in_position(in_position), .feed_increment(feed_increment), .position_droop(position_droop),
        .blocks_done(blocks_done));

    task automatic mismatch(input string m);
        failures++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) mismatch($sformatf("got %h want %h", got, exp));
    endtask

    // ----------------------------------------
    // Bus master and port drivers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic cmp,
                       input logic err, input logic [31:0] ed, output logic [31:0] rdata);
        int n;
        expq.push_back('{cmp: cmp, err: err, data: ed});
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatch("no bus answer");
            close_out();
        end
        rdata = prdata;
        apb_req <= '0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, 1'b0, 1'b0, 32'h0, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, 1'b1, 1'b0, d, x);
    endtask

    task automatic wait_cy(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic gain_at(input logic [15:0] s, input logic [15:0] g);
        motor_speed <= s;
        wait_cy(3);
        chk(32'(speed_gain), 32'(g));
    endtask

    task automatic pulses(input logic d);
        repeat (4) begin
            pulse_in <= 1'b1;
            dir_in <= d;
            @(posedge pclk);
            pulse_in <= 1'b0;
            @(posedge pclk);
        end
    endtask

    always @(posedge pclk) begin
        if (pulse_out === 1'b1) pulse_cnt++;
        if (pready === 1'b1) begin
            if (expq.size() == 0) begin
                mismatch("unexpected bus answer");
            end else begin
                e = expq.pop_front();
                checks++;
                if (pslverr !== e.err || (e.cmp && prdata !== e.data)) mismatch("bus read data or error flag");
            end
        end
    end

    initial begin
        #300000;
        mismatch("run timed out");
        close_out();
    end

    initial begin
        logic [31:0] x;
        int w;
        logic [2:0] dp;
        logic [15:0] fq [5];
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(speed_gain), 32'h64);
        rd(ADDR_INPOS_WINDOW, 32'h32);
        rd(ADDR_FUNC_TWO, 32'h0);
        apb(1'b0, 8'h40, 32'h0, 1'b1, 1'b1, 32'h0, x);
        apb(1'b1, 8'h44, 32'h1, 1'b0, 1'b1, 32'h0, x);
        wr(ADDR_INPOS_WINDOW, 32'hffffffff);
        rd(ADDR_INPOS_WINDOW, 32'h7fff);
        w = ($unsigned($random(seed)) % 1000) + 1;
        wr(ADDR_INPOS_WINDOW, 32'(w));
        for (int k = 0; k < 4; k++) begin
            droop_in <= (k % 2 ? -1 : 1) * (w + k / 2);
            wait_cy(3 * CYCLE);
            chk(32'(in_position), 32'(k < 2));
        end
        $display("test window done");
        wr(ADDR_INPOS_WINDOW, 32'd50);
        droop_in <= 32'sd10;
        run <= 1'b1;
        @(posedge pclk);
        run <= 1'b0;
        w = 0;
        while (blocks_done < 2 && w < 2000) begin
            @(posedge pclk);
            w++;
        end
        if (blocks_done < 2) mismatch("moves never completed");
        wait_cy(3 * CYCLE);
        rd(ADDR_STATUS, 32'h3);
        apb(1'b0, ADDR_SETTLE_TIME, 32'h0, 1'b0, 1'b0, 32'h0, x);
        chk(32'(x >= 2 && x <= 4), 32'h1);
        $display("test settle done");
        wr(ADDR_PRIMARY_GAIN, 32'h0);
        rd(ADDR_PRIMARY_GAIN, 32'h1);
        wr(ADDR_PRIMARY_GAIN, 32'h0000ffff);
        rd(ADDR_PRIMARY_GAIN, 32'h270f);
        wr(ADDR_PRIMARY_GAIN, 32'h4d2);
        wr(ADDR_HIGH_SPEED_GAIN, 32'h1f4);
        wr(ADDR_GAIN_CHANGE_SPEED, 32'h3e8);
        gain_at(16'h03e8, 16'h04d2);
        gain_at(16'h03e9, 16'h01f4);
        wr(ADDR_GAIN_CHANGE_SPEED, 32'h0);
        gain_at(16'h03e9, 16'h04d2);
        gain_at(16'h0000, 16'h04d2);
        $display("test gain done");
        // Every round reverses direction, so each code sees a fresh reversal.
        for (int c = 0; c < 5; c++) begin
            if (c == 4) motor_speed <= 16'h0064;
            wr(ADDR_FUNC_ONE, 32'((c == 4 ? 3 : c) << JITTER_LSB));
            n0 = pulse_cnt;
            pulses(~c[0]);
            wait_cy(3);
            chk(32'(pulse_cnt - n0), 32'(c == 4 ? 4 : 4 - c));
            chk(32'(dir_out), 32'(!c[0]));
        end
        $display("test jitter done");
        for (int i = 0; i < 5; i++) begin
            fq[i] = 16'(($unsigned($random(seed)) % 2170) + 81);
            if (i != 2) wr(fa[i], 32'(fq[i]));
            if (i != 2) rd(fa[i], 32'(fq[i]));
        end
        for (int c = 0; c < 8; c++) begin
            dp = c[2:0];
            wr(ADDR_FUNC_TWO, {24'h0, dp + 3'd1, c[0], dp, 1'b0});
            wr(ADDR_FUNC_SIX, {24'h0, dp + 3'd3, 1'b0, dp + 3'd2, 1'b0});
            wait_cy(2);
            for (int i = 0; i < 5; i++) begin
                if (i != 2) chk(32'(notch_cfg[i]), 32'({1'b1, dp + 3'(i - i / 3), atten[dp + 3'(i - i / 3)], fq[i]}));
            end
            chk(32'(notch_cfg[2]), 32'({c[0], 3'd0, atten[0], 16'h0465}));
        end
        wr(fa[0], 32'h0);
        wr(fa[1], 32'hffff);
        wait_cy(2);
        chk(32'(notch_cfg[0].enable), 32'h0);
        chk(32'(notch_cfg[1].freq_hz), 32'h08ca);
        $display("test notch done");
        resonance_freq <= 16'h02bc;
        wait_cy(3);
        rd(ADDR_RESONANCE_MON, 32'h0);
        res_present <= 1'b1;
        wait_cy(3);
        rd(ADDR_RESONANCE_MON, 32'h2bc);
        $display("test resonance done");
        wait_cy(4);
        if (expq.size() != 0) mismatch("bus answers missing");
        close_out();
    end
endmodule
